/* bench/nfhc_flash_model.sv */
// Behavioural NAND device facing the host controller
module nfhc_flash_model (
	input wire logic       chipSel_n,     // Chip select
	input wire logic       cmdLatch,      // Command latch
	input wire logic       addrLatch,     // Address latch
	input wire logic       writeStrobe_n, // Write strobe
	input wire logic       read_strobe_n, // Read strobe
	input wire logic [7:0] byteBusOut,    // Host bus value
	input wire logic       holdBusy,      // Bench keeps device busy
	output logic     [7:0] byteBusIn,     // Device bus value
	output logic           readyBusyIn    // Ready level
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cmdQ[$], addrQ[$], dataQ[$];
	logic [7:0] col = 8'h00;
	logic [7:0] dout = 8'h5a;
	logic       upper = 1'b0;
	logic       busy = 1'b0;
	int         nAddr = 0;
	logic [13:0] eraseBlk = 14'h0000;
	assign byteBusIn = dout;
	assign readyBusyIn = !(busy || holdBusy);
	task automatic pulse(input int ns);
		fork begin busy = 1'b1; #ns busy = 1'b0; end join_none
	endtask : pulse
	always @(posedge writeStrobe_n) if (!chipSel_n) begin
		if (cmdLatch) begin
			cmdQ.push_back(byteBusOut);
			nAddr = 0;
			upper = (byteBusOut == 8'h01);
			if (byteBusOut == 8'h10 || byteBusOut == 8'hd0) pulse(300);
			// Sixteen pages share one block, so the block is the row over sixteen
			if (byteBusOut == 8'hd0) eraseBlk = {addrQ[1][5:0], addrQ[0]} >> 4;
		end else if (addrLatch) begin
			if (nAddr == 0) col = byteBusOut;
			addrQ.push_back(byteBusOut);
			nAddr++;
			if (nAddr == 3 && cmdQ[$] inside {8'h00, 8'h01, 8'h50}) pulse(200);
		end else dataQ.push_back(byteBusOut);
	end
	always @(negedge read_strobe_n) begin
		dout = col + (upper ? 8'h80 : 8'h00);
		col++;
	end
	// Bus is released after the hold time, so show a changed value
	always @(posedge read_strobe_n) #15 dout = ~dout;
endmodule : nfhc_flash_model

/* bench/nfhc_host_properties.sv */
// Concurrent checks on the ports of the host NAND controller
module nfhc_host_properties
	import nfhc_pkg::*;
(
	input wire logic       mclk,          // Clock
	input wire logic       rst_n,         // Reset, active low
	input wire logic       opStart,       // Start pulse
	input wire nfhc_op_t   opCode,        // Operation
	input wire logic       spareEnable_n, // Spare enable level
	input wire logic       opBusy,        // Busy
	input wire logic       opDone,        // Done pulse
	input wire logic       opError,       // Error level
	input wire logic       chipSel_n,     // Chip select
	input wire logic       cmdLatch,      // Command latch
	input wire logic       addrLatch,     // Address latch
	input wire logic       writeStrobe_n, // Write strobe
	input wire logic       read_strobe_n, // Read strobe
	input wire logic [7:0] byteBusOut,    // Bus value
	input wire logic       byteBusOe,     // Bus enable
	input wire logic       readyBusyIn    // Ready level
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	latch_exclusive_a: assert property (!(cmdLatch && addrLatch)) else $error("both latches high");
	strobe_width_a: assert property ($fell(writeStrobe_n) |-> !writeStrobe_n[*3] ##1 writeStrobe_n)
		else $error("write strobe width wrong");
	write_select_a: assert property (!writeStrobe_n |-> !chipSel_n && byteBusOe && read_strobe_n)
		else $error("write strobe without select");
	byte_hold_a: assert property (!writeStrobe_n && !$past(writeStrobe_n) |-> $stable(byteBusOut) && $stable(cmdLatch))
		else $error("byte moved under strobe");
	read_release_a: assert property (!read_strobe_n |-> !byteBusOe && !chipSel_n)
		else $error("bus driven while reading");
	done_pulse_a: assert property (opDone |=> !opDone && !opBusy) else $error("done not a pulse");
	spare_refuse_a: assert property (opStart && !opBusy && opCode == NFHC_OP_READ_SPARE && spareEnable_n
		|=> opDone && opError) else $error("spare read not refused");
	busy_refuse_a: assert property (opStart && !opBusy && !readyBusyIn
		&& !(opCode inside {NFHC_OP_STATUS, NFHC_OP_RESET}) |=> opDone && opError) else $error("busy op not refused");
endmodule : nfhc_host_properties

bind nfhc_host nfhc_host_properties i_props(.mclk(mclk), .rst_n(rst_n), .opStart(opStart), .opCode(opCode),
	.spareEnable_n(spareEnable_n), .opBusy(opBusy), .opDone(opDone), .opError(opError), .chipSel_n(chipSel_n),
	.cmdLatch(cmdLatch), .addrLatch(addrLatch), .writeStrobe_n(writeStrobe_n), .read_strobe_n(read_strobe_n),
	.byteBusOut(byteBusOut), .byteBusOe(byteBusOe), .readyBusyIn(readyBusyIn));

/* bench/test_nfhc_host.sv */
// Self-checking bench of the host NAND controller
module test_nfhc_host;
	timeunit 1ns;
	timeprecision 1ps;
	import nfhc_pkg::*;
	logic mclk = 0, rst_n = 0, opStart = 0, spare_n = 1, wrValid = 0, holdBusy = 0, err;
	nfhc_op_t opCode = NFHC_OP_STATUS;
	logic [21:0] opAddr = 22'h002a5c;
	logic [7:0] opColumn = 8'h10, wrByte = 8'h00, rdQ[$];
	logic [9:0] opLength = 10'h000, wrIndex = 10'h000;
	logic opBusy, opDone, opError, rdValid, cs_n, cl, al, we_n, re_n, oe, rb;
	logic [7:0] rdByte, bo, bi;
	int num_errors = 0, total_checks = 0, cyc = 0;
	nfhc_host #(.TIMEOUT_CYC(200)) i_nfhc_host(.mclk(mclk), .rst_n(rst_n), .opStart(opStart), .opCode(opCode),
		.opAddr(opAddr), .opColumn(opColumn), .opLength(opLength), .spareEnable_n(spare_n), .wrValid(wrValid),
		.wrIndex(wrIndex), .wrByte(wrByte), .opBusy(opBusy), .opDone(opDone), .opError(opError),
		.rdValid(rdValid), .rdByte(rdByte), .chipSel_n(cs_n), .cmdLatch(cl), .addrLatch(al),
		.writeStrobe_n(we_n), .read_strobe_n(re_n), .byteBusOut(bo), .byteBusOe(oe), .byteBusIn(bi),
		.readyBusyIn(rb));
	nfhc_flash_model i_nfhc_flash_model(.chipSel_n(cs_n), .cmdLatch(cl), .addrLatch(al), .writeStrobe_n(we_n),
		.read_strobe_n(re_n), .byteBusOut(bo), .holdBusy(holdBusy), .byteBusIn(bi), .readyBusyIn(rb));
	always #5 mclk = ~mclk;
	always @(posedge mclk) if (rdValid === 1'b1) rdQ.push_back(rdByte);
	always @(posedge mclk) if (++cyc == 20000) begin
		num_errors++;
		$display("Error cycle limit expected done seen hang");
		tally_and_finish();
	end
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin num_errors++; $display("Error %s expected %h seen %h", what, exp, seen); end
	endtask : check
	task automatic run_op(input nfhc_op_t op, input logic [9:0] len);
		i_nfhc_flash_model.cmdQ.delete(); i_nfhc_flash_model.addrQ.delete(); i_nfhc_flash_model.dataQ.delete();
		rdQ.delete();
		@(negedge mclk) begin opCode = op; opLength = len; opStart = 1; end
		@(negedge mclk) opStart = 0;
		// A refused op shows its done pulse at this very edge; a hang ends at the cycle ceiling
		while (opDone !== 1'b1) @(negedge mclk);
		err = opError;
	endtask : run_op
	task automatic t_codes();
		nfhc_op_t ops[4] = '{NFHC_OP_READ, NFHC_OP_READ_UPPER, NFHC_OP_READ_ID, NFHC_OP_RESET};
		logic [7:0] codes[4] = '{8'h00, 8'h01, 8'h90, 8'hff};
		for (int i = 0; i < 4; i++) begin run_op(ops[i], 0); check("code", i_nfhc_flash_model.cmdQ[0], codes[i]); end
		run_op(NFHC_OP_READ_UPPER, 3);
		check("upper count", 8'(rdQ.size()), 8'h03);
		for (int i = 0; i < 3; i++) check("upper byte", rdQ[i], 8'h90 + i);
		check("addr count", 8'(i_nfhc_flash_model.addrQ.size()), 8'h03);
		run_op(NFHC_OP_READ, 1);
		check("lower byte", rdQ[0], 8'h10);
		$display("test codes done");
	endtask : t_codes
	task automatic t_program();
		for (int i = 0; i < 4; i++) @(negedge mclk) begin wrValid = 1; wrIndex = 10'(i); wrByte = 8'(8'hc3 + i); end
		@(negedge mclk) wrValid = 0;
		run_op(NFHC_OP_PROGRAM, 4);
		check("prog setup", i_nfhc_flash_model.cmdQ[0], 8'h80);
		check("prog confirm", i_nfhc_flash_model.cmdQ[1], 8'h10);
		check("prog col", i_nfhc_flash_model.addrQ[0], 8'h10);
		check("prog row hi", i_nfhc_flash_model.addrQ[2], 8'h2a);
		for (int i = 0; i < 4; i++) check("prog data", i_nfhc_flash_model.dataQ[i], 8'hc3 + i);
		run_op(NFHC_OP_ERASE, 0);
		check("erase setup", i_nfhc_flash_model.cmdQ[0], 8'h60);
		check("erase cmd", i_nfhc_flash_model.cmdQ[1], 8'hd0);
		check("erase count", 8'(i_nfhc_flash_model.addrQ.size()), 8'h02);
		check("erase addr", i_nfhc_flash_model.addrQ[0], 8'h5c);
		check("erase block", i_nfhc_flash_model.eraseBlk[7:0], 8'ha5);
		$display("test program done");
	endtask : t_program
	task automatic t_refuse();
		run_op(NFHC_OP_READ_SPARE, 1);
		check("spare refused", err, 1'b1);
		check("spare no cmd", 8'(i_nfhc_flash_model.cmdQ.size()), 8'h00);
		spare_n = 0;
		run_op(NFHC_OP_READ_SPARE, 1);
		check("spare cmd", i_nfhc_flash_model.cmdQ[0], 8'h50);
		holdBusy = 1;
		run_op(NFHC_OP_PROGRAM, 2);
		check("busy refused", err, 1);
		run_op(NFHC_OP_STATUS, 1);
		check("status taken", err, 1'b0);
		check("status cmd", i_nfhc_flash_model.cmdQ[0], 8'h70);
		run_op(NFHC_OP_RESET, 0);
		check("reset timeout", err, 1'b1);
		holdBusy = 0;
		$display("test refuse done");
	endtask : t_refuse
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (6) @(negedge mclk);
		rst_n = 1;
		t_codes();
		t_program();
		t_refuse();
		tally_and_finish();
	end
endmodule : test_nfhc_host

/* pkg/nfhc_cfg.svh */
// Constants of the host NAND command controller: command codes, geometry, timing counts
`ifndef NFHC_CFG_SVH
`define NFHC_CFG_SVH

`define NFHC_CMD_READ0     8'h00
`define NFHC_CMD_READ1     8'h01
`define NFHC_CMD_READSPARE 8'h50
`define NFHC_CMD_READID    8'h90
`define NFHC_CMD_RESET     8'hff
`define NFHC_CMD_PROG      8'h80
`define NFHC_CMD_PROGCONF  8'h10
`define NFHC_CMD_ERASE     8'h60
`define NFHC_CMD_ERASECONF 8'hd0
`define NFHC_CMD_STATUS    8'h70

`define NFHC_PAGE_BYTES    528
`define NFHC_MAIN_BYTES    512
`define NFHC_PAGES         16384
`define NFHC_PAGES_PER_BLK 16
`define NFHC_BLOCKS        1024

`define NFHC_CLK_NS        10
`define NFHC_STROBE_NS     50
`define NFHC_STROBE_CYC    ((`NFHC_STROBE_NS + `NFHC_CLK_NS - 1) / `NFHC_CLK_NS)
`define NFHC_TIMEOUT_MS    3
`define NFHC_TIMEOUT_CYC   (`NFHC_TIMEOUT_MS * 1000000 / `NFHC_CLK_NS)

`endif

/* pkg/nfhc_pkg.sv */
// Types of the host NAND command controller
package nfhc_pkg;
	typedef enum logic [2:0] {
		NFHC_OP_READ,
		NFHC_OP_READ_UPPER,
		NFHC_OP_READ_SPARE,
		NFHC_OP_PROGRAM,
		NFHC_OP_ERASE,
		NFHC_OP_READ_ID,
		NFHC_OP_STATUS,
		NFHC_OP_RESET
	} nfhc_op_t;

	typedef enum logic [1:0] {
		NFHC_CYC_CMD,
		NFHC_CYC_ADDR,
		NFHC_CYC_WDATA,
		NFHC_CYC_RDATA
	} nfhc_cyc_t;
endpackage : nfhc_pkg

/* verilog/nfhc_host.sv */
// Host controller that sequences commands, addresses and data onto a NAND byte bus
// Function
// R1 - 16384 pages of 528 bytes, spare 512-527
// R2 - Device buffers transfers in 528-byte register
// R3 - Erase works on whole blocks only
// R4 - One block spans sixteen consecutive pages
// R5 - Bytes driven while write strobe pulses low
// R6 - Command latch for commands, address latch otherwise; the code sends data bytes with both latches low
// R7 - Erase is 60h, row bytes, then D0h
// R8 - Three address bytes; erase uses two
// R9 - Program is 80h, address, data, 10h
// R10 - Code 00h reads from first half
// R11 - Code 01h reads from second half
// R12 - Second-half pointer reverts after one operation
// R13 - Spare read 50h only with spare enable low
// R14 - Identifier 90h, reset FFh, status 70h
// R15 - While busy only reset and status
// R16 - Never issue undefined command codes
// R17 - Extra address bytes are ignored by device
// R18 - Each read strobe fall yields next byte
// R19 - Ready/busy low while operation runs
// R20 - Poll ready/busy, time out if stuck
`include "nfhc_cfg.svh"
module nfhc_host
	import nfhc_pkg::*;
#(
	parameter int TIMEOUT_CYC = `NFHC_TIMEOUT_CYC,
	parameter int STROBE_CYC  = `NFHC_STROBE_CYC,
	parameter int PAGE_BYTES  = `NFHC_PAGE_BYTES
) (
	input  wire logic        mclk,         // System clock
	input  wire logic        rst_n,        // Asynchronous reset, active low
	input  wire logic        opStart,      // Start pulse for a new operation
	input  wire nfhc_op_t    opCode,       // Operation to run
	input  wire logic [21:0] opAddr,       // Page address for read, program and erase
	input  wire logic [7:0]  opColumn,     // Starting column within a half
	input  wire logic [9:0]  opLength,     // Bytes to move in the data phase
	input  wire logic        spareEnable_n,// Spare-area enable level seen by the device
	input  wire logic        wrValid,      // Loading byte for the page buffer
	input  wire logic [9:0]  wrIndex,      // Index of the byte being loaded
	input  wire logic [7:0]  wrByte,       // Byte to load
	output logic             opBusy,       // Operation in progress
	output logic             opDone,       // Pulse at end of operation
	output logic             opError,      // Operation refused or timed out
	output logic             rdValid,      // Pulse with a byte read from the device
	output logic [7:0]       rdByte,       // Byte read from the device
	output logic             chipSel_n,    // Chip select, active low
	output logic             cmdLatch,     // Command latch strobe
	output logic             addrLatch,    // Address latch strobe
	output logic             writeStrobe_n,// Write strobe, active low
	output logic             read_strobe_n,// Read strobe, active low
	output logic [7:0]       byteBusOut,   // byte_bus output value
	output logic             byteBusOe,    // byte_bus output enable
	input  wire logic [7:0]  byteBusIn,    // byte_bus input value
	input  wire logic        readyBusyIn   // Open-drain ready/busy, low while busy
);
	// The strobe counter is eight bits and the buffer index ten bits wide
	if (STROBE_CYC < 2 || STROBE_CYC > 255) begin : g_bad_strobe
		$error("nfhc_host: STROBE_CYC must lie between 2 and 255");
	end
	if (PAGE_BYTES > 1024) begin : g_bad_page
		$error("nfhc_host: PAGE_BYTES too large");
	end

	typedef enum logic [2:0] {IDLE, DRIVE, HOLD, NEXT, WAITRB, DONE} nfhc_state_t;

	// ----------------------------------------
	// Command selection
	// ----------------------------------------
	function automatic logic [7:0] first_code(nfhc_op_t op);
		case (op)
			NFHC_OP_READ:       first_code = `NFHC_CMD_READ0;    // see R10
			NFHC_OP_READ_UPPER: first_code = `NFHC_CMD_READ1;    // see R11
			NFHC_OP_READ_SPARE: first_code = `NFHC_CMD_READSPARE;
			NFHC_OP_PROGRAM:    first_code = `NFHC_CMD_PROG;     // see R9
			NFHC_OP_ERASE:      first_code = `NFHC_CMD_ERASE;    // see R7
			NFHC_OP_READ_ID:    first_code = `NFHC_CMD_READID;   // see R14
			NFHC_OP_STATUS:     first_code = `NFHC_CMD_STATUS;
			default:            first_code = `NFHC_CMD_RESET;
		endcase
	endfunction : first_code

	nfhc_state_t state;
	nfhc_op_t    op;
	nfhc_cyc_t   cyc;
	logic [2:0]  addrLeft;
	logic [9:0]  dataLeft;
	logic [9:0]  bufIdx;
	logic [7:0]  strobeCnt;
	logic [31:0] waitCnt;
	logic [21:0] addrReg;
	logic [7:0]  colReg;
	logic        confSent;
	logic [7:0]  bufRd;

	// Only reset and status may be issued while the device reports busy
	wire busyOk     = (opCode == NFHC_OP_RESET) || (opCode == NFHC_OP_STATUS);     // see R15
	// Spare read is only defined with the enable strapped low
	wire spareOk    = (opCode != NFHC_OP_READ_SPARE) || !spareEnable_n;            // see R13
	wire acceptOp   = opStart && (state == IDLE) && spareOk && (readyBusyIn || busyOk);
	wire refuseOp   = opStart && (state == IDLE) && !acceptOp;
	wire hasAddr    = (op != NFHC_OP_RESET) && (op != NFHC_OP_STATUS);
	// Erase sends the two row bytes; ID sends one; read and program use the full three
	wire [2:0] addrNum = (op == NFHC_OP_ERASE) ? 3'h2 :                            // see R8
		(op == NFHC_OP_READ_ID) ? 3'h1 : 3'h3;
	wire [1:0] addrPos = addrNum[1:0] - addrLeft[1:0];
	wire [7:0] addrByte = (op == NFHC_OP_ERASE) ?
		((addrPos == 2'h0) ? addrReg[7:0] : {2'h0, addrReg[13:8]}) :
		(addrPos == 2'h0) ? colReg :
		(addrPos == 2'h1) ? addrReg[7:0] : {2'h0, addrReg[13:8]};
	wire        isProg   = (op == NFHC_OP_PROGRAM);
	wire        isRead   = (op == NFHC_OP_READ) || (op == NFHC_OP_READ_UPPER) ||
		(op == NFHC_OP_READ_SPARE) || (op == NFHC_OP_READ_ID) || (op == NFHC_OP_STATUS);
	wire        needsRb  = isProg || (op == NFHC_OP_ERASE) || (op == NFHC_OP_RESET) ||
		(op == NFHC_OP_READ) || (op == NFHC_OP_READ_UPPER) || (op == NFHC_OP_READ_SPARE);
	wire        halfStrobe = (strobeCnt == 8'(STROBE_CYC / 2));
	wire        strobeEnd  = (strobeCnt == 8'(STROBE_CYC - 1));
	wire [7:0]  secondCode = isProg ? `NFHC_CMD_PROGCONF : `NFHC_CMD_ERASECONF;

	nfhc_page_buf #(.DEPTH(PAGE_BYTES), .AW(10)) i_nfhc_page_buf (
		.mclk   (mclk),
		.wrEn   (wrValid),
		.wrAddr (wrIndex),
		.wrData (wrByte),
		.rdAddr (bufIdx),
		.rdData (bufRd)
	);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= IDLE;
			op <= NFHC_OP_RESET;
			cyc <= NFHC_CYC_CMD;
			addrLeft <= 3'h0;
			dataLeft <= 10'h000;
			bufIdx <= 10'h000;
			strobeCnt <= 8'h00;
			waitCnt <= 32'h0;
			addrReg <= 22'h0;
			colReg <= 8'h00;
			confSent <= 1'b0;
			opBusy <= 1'b0;
			opDone <= 1'b0;
			opError <= 1'b0;
			rdValid <= 1'b0;
			rdByte <= 8'h00;
			chipSel_n <= 1'b1;
			cmdLatch <= 1'b0;
			addrLatch <= 1'b0;
			writeStrobe_n <= 1'b1;
			read_strobe_n <= 1'b1;
			byteBusOut <= 8'h00;
			byteBusOe <= 1'b0;
		end else begin
			opDone <= 1'b0;
			rdValid <= 1'b0;
			case (state)
				IDLE: begin
					chipSel_n <= 1'b1;
					if (refuseOp) begin
						opError <= 1'b1;
						opDone <= 1'b1;
					end else if (acceptOp) begin
						// Only codes of the defined set can leave this block
						op <= opCode;                                          // see R16
						addrReg <= opAddr;
						colReg <= opColumn;
						dataLeft <= opLength;
						bufIdx <= 10'h000;
						addrLeft <= 3'h0;
						confSent <= 1'b0;
						opBusy <= 1'b1;
						opError <= 1'b0;
						cyc <= NFHC_CYC_CMD;
						byteBusOut <= first_code(opCode);
						strobeCnt <= 8'h00;
						state <= DRIVE;
					end
				end
				DRIVE: begin
					// Strobe falls on the same edge as select and latch lines; only data was set a cycle earlier
					chipSel_n <= 1'b0;
					cmdLatch <= (cyc == NFHC_CYC_CMD);                         // see R6
					addrLatch <= (cyc == NFHC_CYC_ADDR);                       // see R6
					byteBusOe <= (cyc != NFHC_CYC_RDATA);
					if (cyc == NFHC_CYC_RDATA) read_strobe_n <= 1'b0;          // see R18
					else writeStrobe_n <= 1'b0;                                // see R5
					strobeCnt <= 8'h00;
					state <= HOLD;
				end
				HOLD: begin
					strobeCnt <= strobeCnt + 8'h01;
					if (halfStrobe) begin
						// Device latches on this rising edge; data held a half period more
						writeStrobe_n <= 1'b1;                                 // see R5
						if (cyc == NFHC_CYC_RDATA) begin
							read_strobe_n <= 1'b1;
							rdByte <= byteBusIn;
							rdValid <= 1'b1;
						end
					end
					if (strobeEnd) state <= NEXT;
				end
				NEXT: begin
					cmdLatch <= 1'b0;
					addrLatch <= 1'b0;
					state <= DRIVE;
					if (cyc == NFHC_CYC_CMD && !confSent && hasAddr) begin
						cyc <= NFHC_CYC_ADDR;
						addrLeft <= addrNum - 3'h1;
						byteBusOut <= (addrNum == 3'h2) ? addrReg[7:0] : colReg;
					end else if (cyc == NFHC_CYC_ADDR && addrLeft != 3'h0) begin
						addrLeft <= addrLeft - 3'h1;
						byteBusOut <= addrByte;
					end else if (cyc == NFHC_CYC_ADDR && isProg && dataLeft != 10'h000) begin
						cyc <= NFHC_CYC_WDATA;
						byteBusOut <= bufRd;
						bufIdx <= bufIdx + 10'h001;
						dataLeft <= dataLeft - 10'h001;
					end else if (cyc == NFHC_CYC_WDATA && dataLeft != 10'h000) begin
						byteBusOut <= bufRd;
						bufIdx <= bufIdx + 10'h001;
						dataLeft <= dataLeft - 10'h001;
					end else if (!confSent && (isProg || op == NFHC_OP_ERASE)) begin
						cyc <= NFHC_CYC_CMD;
						confSent <= 1'b1;
						byteBusOut <= secondCode;                              // see R7
					end else if (isRead && !needsRb && dataLeft != 10'h000) begin
						byteBusOe <= 1'b0;
						cyc <= NFHC_CYC_RDATA;
						dataLeft <= dataLeft - 10'h001;
					end else begin
						byteBusOe <= 1'b0;
						waitCnt <= 32'h0;
						state <= needsRb ? WAITRB : DONE;
					end
				end
				WAITRB: begin
					// Poll ready/busy; a stuck line ends in a timeout
					waitCnt <= waitCnt + 32'h1;                                // see R20
					if (waitCnt > 32'(STROBE_CYC) && readyBusyIn) begin        // see R19
						if (isRead && dataLeft != 10'h000) begin
							op <= NFHC_OP_STATUS;
							cyc <= NFHC_CYC_RDATA;
							dataLeft <= dataLeft - 10'h001;
							state <= DRIVE;
						end else state <= DONE;
					end else if (waitCnt == 32'(TIMEOUT_CYC)) begin
						opError <= 1'b1;
						state <= DONE;
					end
				end
				DONE: begin
					chipSel_n <= 1'b1;
					opBusy <= 1'b0;
					opDone <= 1'b1;
					state <= IDLE;
				end
				default: state <= IDLE;
			endcase
		end
	end
endmodule : nfhc_host

/* verilog/nfhc_page_buf.sv */
// Page-wide data buffer of the host controller with registered read data
module nfhc_page_buf #(
	parameter int DEPTH = 528,
	parameter int AW    = 10
) (
	input  wire logic          mclk,   // System clock
	input  wire logic          wrEn,   // Write strobe
	input  wire logic [AW-1:0] wrAddr, // Write address
	input  wire logic [7:0]    wrData, // Write data
	input  wire logic [AW-1:0] rdAddr, // Read address
	output logic      [7:0]    rdData  // Registered read data
);
	// Refuse an address width that cannot reach every byte of the buffer
	if (DEPTH > (1 << AW)) begin : g_bad_aw
		$error("nfhc_page_buf: AW too small");
	end

	logic [7:0] mem [DEPTH];

	always_ff @(posedge mclk) begin
		if (wrEn) mem[wrAddr] <= wrData;
	end

	always_ff @(posedge mclk) begin
		rdData <= mem[rdAddr];
	end
endmodule : nfhc_page_buf
